/* File: rtl/uart_register_address_decode.v */
`timescale 1ns/100ps
`include "uart_regmap_map.vh"

module uart_register_address_decode (
   // Clock and reset.
   input  wire       i_clock,
   input  wire       i_rst,
   // Host register port.
   // One strobe high for one cycle per access; the address
   // and data must stand through the taking edge.
   input  wire [2:0] i_addr,
   input  wire       i_rd,
   input  wire       i_wr,
   input  wire [7:0] i_wdata,
   output reg  [7:0] o_rdata,
   // Status supplied by the serial engine.
   input  wire [7:0] i_receive_holding,
   input  wire [7:0] i_interrupt_status,
   input  wire [7:0] i_line_status,
   input  wire [7:0] i_modem_status,
   input  wire [7:0] i_fifo_level_count,
   // Strobes to the serial engine for side-effect locations.
   // They are combinational, so the engine acts on the same
   // edge that takes the access.
   output wire       o_rx_pop,
   output wire       o_tx_push,
   output wire       o_queue_control_wr,
   output wire       o_trigger_wr,
   output wire       o_mode_select_wr,
   output wire       o_status_read,
   output wire       o_modem_read,
   // Register contents for the rest of the device.
   // Each comes straight from its flop, so it never glitches.
   output wire [7:0] o_line_control,
   output wire [7:0] o_divisor_low,
   output wire [7:0] o_divisor_high,
   output wire [7:0] o_divisor_fraction,
   output wire [7:0] o_interrupt_enable,
   output wire [7:0] o_modem_control,
   output wire [7:0] o_feature_control,
   output wire [7:0] o_enhanced_function,
   output wire [7:0] o_rs485_setup_hysteresis,
   output wire [7:0] o_special_function,
   output wire [7:0] o_scratch_pad,
   output wire [7:0] o_queue_control,
   output wire [7:0] o_fifo_trigger_level,
   output wire [7:0] o_enhanced_mode_select,
   output wire [7:0] o_flow_resume_char_1,
   output wire [7:0] o_flow_resume_char_2,
   output wire [7:0] o_flow_pause_char_1,
   output wire [7:0] o_flow_pause_char_2,
   output wire [7:0] o_pin_irq_enable,
   output wire [7:0] o_pin_three_state,
   output wire [7:0] o_pin_polarity,
   output wire [7:0] o_pin_function_select
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Every stored register lives here as a flop.
   // Write-only registers are kept too, because the rest
   // of the device needs their contents even though the
   // host can never read them back.
   reg [7:0] line_control;         // Bank selector and framing.
   reg [7:0] divisor_low;          // Baud divisor, low byte.
   reg [7:0] divisor_high;         // Baud divisor, high byte.
   reg [7:0] divisor_fraction;     // Fractional divisor.
   reg [7:0] interrupt_enable;     // Interrupt enables.
   reg [7:0] modem_control;        // Modem outputs and modes.
   reg [7:0] feature_control;      // Feature control, page bit.
   reg [7:0] enhanced_function;    // Enhanced function enable.
   reg [7:0] rs485_setup_hysteresis; // Write-only setup.
   reg [7:0] special_function;     // Write-only, pin page bit.
   reg [7:0] scratch_pad;          // Free scratch byte.
   reg [7:0] queue_control;        // Last queue control write.
   reg [7:0] fifo_trigger_level;   // Write-only trigger level.
   reg [7:0] enhanced_mode_select; // Write-only mode select.
   // The paged sets are small arrays indexed by the low
   // two address bits.
   reg [7:0] flow_char [0:3];      // Resume 1, 2, pause 1, 2.
   reg [7:0] pin_reg   [0:3];      // Irq, three-state, pol, sel.

   // ----------------------------------------------------------------
   // Bank qualifiers
   // ----------------------------------------------------------------
   // All qualifiers come from register state before the edge,
   // so a write to line control moves the bank only for the
   // access after it.
   // The enhanced key takes precedence over the divisor bit, since
   // the key value itself has bit 7 set.
   wire enh_bank = (line_control == `ENH_KEY);
   wire dlab     = line_control[`DLAB_BIT] & ~enh_bank;
   // Enhancement enable gates the fraction and special locations.
   wire enh_on   = enhanced_function[`ENH_FN_BIT];
   // Pin page selects the pin set in the enhanced upper half.
   wire pin_page = special_function[`SPEC_PIN_BIT];
   // Feature page turns 111 into mode select and level count.
   wire feat_page = feature_control[`FEAT_PAGE_BIT];
   // A zero divisor means the revision code sits at 000.
   // Writes still reach the divisor, so it can leave zero.
   wire div_zero = (divisor_low == `DIV_ZERO) &&
                   (divisor_high == `DIV_ZERO);
   // Address 010 in the normal bank: with enhancement on, the
   // divisor bit hands the location to the fraction register.
   wire status_sel = ~enh_bank & (enh_on ? ~dlab : 1'b1);
   wire frac_sel = dlab & enh_on;
   // Address decodes used by the strobes; only the locations
   // with side effects need one.
   wire a0 = (i_addr == `A_0);
   wire a2 = (i_addr == `A_2);
   wire a5 = (i_addr == `A_5);
   wire a6 = (i_addr == `A_6);
   wire a7 = (i_addr == `A_7);
   wire [1:0] hi_idx = i_addr[1:0];

   // ----------------------------------------------------------------
   // Side-effect strobes, combinational with the access
   // ----------------------------------------------------------------
   // A strobe fires only where the access really reaches the
   // engine's location. A pop or push on a wrong-bank access
   // would lose or invent a byte, which the host cannot undo.
   // The status reads are silent in the enhanced bank, where
   // the upper half belongs to the paged sets.
   assign o_rx_pop  = i_rd & a0 & ~enh_bank & ~dlab;
   assign o_tx_push = i_wr & a0 & ~enh_bank & ~dlab;
   assign o_queue_control_wr = i_wr & a2 & status_sel;
   assign o_trigger_wr       = i_wr & a0 & enh_bank;
   assign o_mode_select_wr   = i_wr & a7 & ~enh_bank & feat_page
                               & ~pin_page;
   assign o_status_read = i_rd & a5 & ~enh_bank;
   assign o_modem_read  = i_rd & a6 & ~enh_bank;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // One write lands in at most one register. The case picks
   // by address and the bank qualifiers pick within it.
   // A write with both strobes high still writes; the read
   // side acts on its own.
   // The paged sets are handled after the case, which writes
   // nothing at their locations in the enhanced bank.
   // Writes aimed at read aliases reach the write-only register at
   // the same address; only unmapped or locked locations move no state.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         // Line control leaves reset in the normal bank with
         // an eight-bit frame; all else clears.
         line_control           <= `LINE_CTL_RESET;
         divisor_low            <= `REG_RESET;
         divisor_high           <= `REG_RESET;
         divisor_fraction       <= `REG_RESET;
         interrupt_enable       <= `REG_RESET;
         modem_control          <= `REG_RESET;
         feature_control        <= `REG_RESET;
         enhanced_function      <= `REG_RESET;
         rs485_setup_hysteresis <= `REG_RESET;
         special_function       <= `REG_RESET;
         scratch_pad            <= `REG_RESET;
         queue_control          <= `REG_RESET;
         fifo_trigger_level     <= `REG_RESET;
         enhanced_mode_select   <= `REG_RESET;
         flow_char[0] <= `REG_RESET;
         flow_char[1] <= `REG_RESET;
         flow_char[2] <= `REG_RESET;
         flow_char[3] <= `REG_RESET;
         pin_reg[0]   <= `REG_RESET;
         pin_reg[1]   <= `REG_RESET;
         pin_reg[2]   <= `REG_RESET;
         pin_reg[3]   <= `REG_RESET;
      end else if (i_wr) begin
         case (i_addr)
            `A_0: begin
               if (enh_bank) begin
                  fifo_trigger_level <= i_wdata;
               end else if (dlab) begin
                  divisor_low <= i_wdata;
               end
            end
            `A_1: begin
               if (enh_bank) begin
                  feature_control <= i_wdata;
               end else if (dlab) begin
                  divisor_high <= i_wdata;
               end else begin
                  interrupt_enable <= i_wdata;
               end
            end
            `A_2: begin
               if (enh_bank) begin
                  enhanced_function <= i_wdata;
               end else if (frac_sel) begin
                  divisor_fraction <= i_wdata;
               end else if (status_sel) begin
                  queue_control <= i_wdata;
               end
            end
            `A_3: begin
               line_control <= i_wdata;
            end
            `A_4: begin
               if (!enh_bank) begin
                  modem_control <= i_wdata;
               end
            end
            `A_5: begin
               if (!enh_bank) begin
                  rs485_setup_hysteresis <= i_wdata;
               end
            end
            `A_6: begin
               if (!enh_bank && enh_on) begin
                  special_function <= i_wdata;
               end
            end
            `A_7: begin
               if (!enh_bank && !pin_page) begin
                  if (feat_page) begin
                     enhanced_mode_select <= i_wdata;
                  end else begin
                     scratch_pad <= i_wdata;
                  end
               end
            end
            default: begin
            end
         endcase
         // Upper half of the enhanced bank: paged by the pin bit.
         // The case above writes nothing there in this bank,
         // so the two paths never meet on one register.
         if (enh_bank && i_addr[2]) begin
            if (pin_page) begin
               pin_reg[hi_idx] <= i_wdata;
            end else begin
               flow_char[hi_idx] <= i_wdata;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   // The read mux mirrors the write decode, with the read
   // aliases in place of the write-only registers.
   // Status bytes come live from the engine and are caught
   // in the read cycle, so the host sees them as they stood
   // on the taking edge.
   // Read data is registered; it appears the cycle after i_rd.
   // Unmapped combinations read as zero and change nothing.
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      case (i_addr)
         `A_0: begin
            if (enh_bank) begin
               next_rdata = i_fifo_level_count;
            end else if (dlab && div_zero) begin
               next_rdata = `REV_CODE;
            end else if (dlab) begin
               next_rdata = divisor_low;
            end else begin
               next_rdata = i_receive_holding;
            end
         end
         `A_1: begin
            if (enh_bank) begin
               next_rdata = feature_control;
            end else if (dlab) begin
               next_rdata = divisor_high;
            end else begin
               next_rdata = interrupt_enable;
            end
         end
         `A_2: begin
            if (enh_bank) begin
               next_rdata = enhanced_function;
            end else if (frac_sel) begin
               next_rdata = divisor_fraction;
            end else if (status_sel) begin
               next_rdata = i_interrupt_status;
            end
         end
         `A_3: begin
            next_rdata = line_control;
         end
         `A_4: begin
            if (!enh_bank) begin
               next_rdata = modem_control;
            end
         end
         `A_5: begin
            next_rdata = i_line_status;
         end
         `A_6: begin
            next_rdata = i_modem_status;
         end
         `A_7: begin
            if (!enh_bank && !pin_page) begin
               if (feat_page) begin
                  next_rdata = i_fifo_level_count;
               end else begin
                  next_rdata = scratch_pad;
               end
            end
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
      // The enhanced bank overrides 100..111 for the paged sets.
      // This also hides the status bytes there, which matches
      // the silent status strobes.
      if (enh_bank && i_addr[2]) begin
         if (pin_page) begin
            next_rdata = pin_reg[hi_idx];
         end else begin
            next_rdata = flow_char[hi_idx];
         end
      end
   end

   // Holding the last value between reads keeps the bus quiet.
   // The cost is one cycle of latency on every read, which
   // the host port easily absorbs.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Register contents out
   // ----------------------------------------------------------------
   // Plain copies of the flops for the serial engine,
   // the baud generator and the pin logic.
   // Nothing here is gated by bank, since the rest of the
   // device needs the contents at all times.
   assign o_line_control           = line_control;
   assign o_divisor_low            = divisor_low;
   assign o_divisor_high           = divisor_high;
   assign o_divisor_fraction       = divisor_fraction;
   assign o_interrupt_enable       = interrupt_enable;
   assign o_modem_control          = modem_control;
   assign o_feature_control        = feature_control;
   assign o_enhanced_function      = enhanced_function;
   assign o_rs485_setup_hysteresis = rs485_setup_hysteresis;
   assign o_special_function       = special_function;
   assign o_scratch_pad            = scratch_pad;
   assign o_queue_control          = queue_control;
   assign o_fifo_trigger_level     = fifo_trigger_level;
   assign o_enhanced_mode_select   = enhanced_mode_select;
   // Flow characters in address order, resume pair first.
   // The flow logic compares received bytes against them.
   assign o_flow_resume_char_1     = flow_char[0];
   assign o_flow_resume_char_2     = flow_char[1];
   assign o_flow_pause_char_1      = flow_char[2];
   assign o_flow_pause_char_2      = flow_char[3];
   // Pin set in address order.
   // The pin logic applies them without further decode.
   assign o_pin_irq_enable         = pin_reg[0];
   assign o_pin_three_state        = pin_reg[1];
   assign o_pin_polarity           = pin_reg[2];
   assign o_pin_function_select    = pin_reg[3];

endmodule

/* File: rtl/uart_regmap_map.vh */
// Notes on behaviour
// - Revision code when divisor zero, bank normal-divisor
// - Divisor bytes at 000/001 when bit7 set, outside the enhanced bank
// - Fraction divisor at 010 needs enhanced bit4
// - Bit7 clear: 000 reads receive, writes transmit
// - Interrupt enable at 001 in normal bank
// - 010 reads status, writes queue control
// - Line control always at 011
// - Modem control at 100 in normal bank
// - 101 reads line status, writes setup register
// - 110 reads modem status, writes special function
// - Scratch pad at 111 in plain page
// - 111 writes mode select, reads level count
// - Enhanced bank 000: level count, trigger write
// - Enhanced bank: feature 001, enhanced function 010
// - Enhanced bank page 0: four flow characters
// - Enhanced bank page 1: four pin registers
// - Three-bit address, qualifiers pick the register
`ifndef UART_REGMAP_MAP_VH
`define UART_REGMAP_MAP_VH

// ----------------------------------------------------------------
// Addresses, qualifiers and reset values
// ----------------------------------------------------------------
`define A_0            3'h0
`define A_1            3'h1
`define A_2            3'h2
`define A_3            3'h3
`define A_4            3'h4
`define A_5            3'h5
`define A_6            3'h6
`define A_7            3'h7
`define ENH_KEY        8'hBF
`define DIV_ZERO       8'h00
`define DLAB_BIT       7
`define ENH_FN_BIT     4
`define FEAT_PAGE_BIT  6
`define SPEC_PIN_BIT   0
`define REG_RESET      8'h00
`define LINE_CTL_RESET 8'h03
// The revision code value is arbitrary.
`define REV_CODE       8'h5A

`endif

/* File: test/uart_engine_model.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Serial engine stand-in that feeds the status inputs
// ----------------------------------------------------------------
module uart_engine_model (
   // Clock, reset and pop strobe from the decoder.
   input  wire       i_clock,
   input  wire       i_rst,
   input  wire       i_rx_pop,
   // Status bytes presented to the decoder.
   output reg  [7:0] o_receive_holding,
   output wire [7:0] o_interrupt_status,
   output wire [7:0] o_line_status,
   output wire [7:0] o_modem_status,
   output wire [7:0] o_fifo_level_count
);
   // Fixed, distinct status patterns so a wrong read path stands out.
   assign o_interrupt_status = 8'hC1;
   assign o_line_status      = 8'h61;
   assign o_modem_status     = 8'hA5;
   assign o_fifo_level_count = 8'h20;

   // Each pop advances the receive byte, so a read that forgets the pop
   // returns a stale value on the next read.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_receive_holding <= 8'h30;
      end else if (i_rx_pop) begin
         o_receive_holding <= o_receive_holding + 8'h01;
      end
   end
endmodule

/* File: test/uart_decode_checker.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Port-level checks of the register decoder
// ----------------------------------------------------------------
module uart_decode_checker (
   input wire       i_clock,
   input wire       i_rst,
   input wire [2:0] i_addr,
   input wire       i_rd,
   input wire       i_wr,
   input wire [7:0] i_wdata,
   input wire [7:0] i_line_status,
   input wire [7:0] o_rdata,
   input wire       o_rx_pop,
   input wire       o_tx_push,
   input wire       o_trigger_wr,
   input wire       o_mode_select_wr,
   input wire [7:0] o_line_control,
   input wire [7:0] o_divisor_low,
   input wire [7:0] o_feature_control,
   input wire [7:0] o_special_function,
   input wire [7:0] o_enhanced_function,
   input wire [7:0] o_scratch_pad,
   input wire [7:0] o_flow_resume_char_1
);
   wire key = (o_line_control == 8'hBF); // Enhanced bank is open.
   wire top = !key && !o_special_function[0]; // Plain upper page.

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // Write cycles for the line control check and the page-0 flow character check.
   sequence s_line_wr;
      i_wr && i_addr == 3'h3;
   endsequence
   sequence s_flow_wr;
      i_wr && i_addr == 3'h4 && key && !o_special_function[0];
   endsequence

   a_line_ctl_write : assert property (
      s_line_wr |=> o_line_control == $past(i_wdata))
      else $error("line control write lost");
   a_rx_pop_read : assert property (
      i_rd && i_addr == 3'h0 && !o_line_control[7] |-> o_rx_pop)
      else $error("receive read without pop");
   a_tx_push_write : assert property (
      i_wr && i_addr == 3'h0 && !o_line_control[7] |-> o_tx_push)
      else $error("transmit write without push");
   a_fifo_trigger_level_key_write : assert property (
      i_wr && i_addr == 3'h0 && key |-> o_trigger_wr && !o_tx_push)
      else $error("trigger write misrouted");
   a_div_low_write : assert property (
      i_wr && i_addr == 3'h0 && o_line_control[7] && !key
      |=> o_divisor_low == $past(i_wdata))
      else $error("divisor low write lost");
   a_lsr_read_data : assert property (
      i_rd && i_addr == 3'h5 && !key |=> o_rdata == $past(i_line_status))
      else $error("line status read wrong");
   a_scratch_write : assert property (
      i_wr && i_addr == 3'h7 && top && !o_feature_control[6]
      |=> o_scratch_pad == $past(i_wdata))
      else $error("scratch write lost");
   a_mode_sel_write : assert property (
      i_wr && i_addr == 3'h7 && top && o_feature_control[6]
      |-> o_mode_select_wr ##1 $stable(o_scratch_pad))
      else $error("mode select write misrouted");
   a_sfr_guarded : assert property (
      i_wr && i_addr == 3'h6 && !o_enhanced_function[4]
      |=> $stable(o_special_function))
      else $error("special function written while locked");
   a_flow_char_wr : assert property (
      s_flow_wr |=> o_flow_resume_char_1 == $past(i_wdata))
      else $error("flow character write lost");
   a_rdata_holds : assert property (
      !i_rd |=> $stable(o_rdata))
      else $error("read data moved without a read");
endmodule

bind uart_register_address_decode uart_decode_checker uart_decode_checker_inst (
   .i_clock, .i_rst, .i_addr, .i_rd, .i_wr, .i_wdata, .i_line_status,
   .o_rdata, .o_rx_pop, .o_tx_push, .o_trigger_wr, .o_mode_select_wr,
   .o_line_control, .o_divisor_low, .o_feature_control,
   .o_special_function, .o_enhanced_function, .o_scratch_pad,
   .o_flow_resume_char_1);

/* File: test/uart_register_address_decode_tb.sv */
`timescale 1ns/100ps
`include "uart_regmap_map.vh"

module uart_register_address_decode_tb;
   logic       i_clock, i_rst, i_rd, i_wr;  // Clock, reset and strobes.
   logic [2:0] i_addr;                      // Register address.
   logic [7:0] i_wdata, sb;                 // Write data, strobe snapshot.
   int         n_mismatch = 0;              // Mismatches seen.
   int         checked = 0;                 // Comparisons made.
   wire  [7:0] i_receive_holding, i_interrupt_status, i_line_status;
   wire  [7:0] i_modem_status, i_fifo_level_count, o_rdata;
   wire  [7:0] o_line_control, o_scratch_pad, o_queue_control;
   wire  [7:0] o_rs485_setup_hysteresis, o_special_function;
   wire  [7:0] o_fifo_trigger_level, o_enhanced_mode_select;
   wire  [7:0] o_divisor_fraction, o_flow_resume_char_1;
   wire  [7:0] o_pin_irq_enable, o_pin_function_select;
   wire        o_rx_pop, o_tx_push, o_queue_control_wr, o_trigger_wr;
   wire        o_mode_select_wr, o_status_read, o_modem_read;

   uart_register_address_decode uart_register_address_decode_inst (
      .i_clock, .i_rst, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata,
      .i_receive_holding, .i_interrupt_status, .i_line_status,
      .i_modem_status, .i_fifo_level_count, .o_rx_pop, .o_tx_push,
      .o_queue_control_wr, .o_trigger_wr, .o_mode_select_wr,
      .o_status_read, .o_modem_read, .o_line_control, .o_divisor_low(),
      .o_divisor_high(), .o_divisor_fraction, .o_interrupt_enable(),
      .o_modem_control(), .o_feature_control(), .o_enhanced_function(),
      .o_rs485_setup_hysteresis, .o_special_function, .o_scratch_pad,
      .o_queue_control, .o_fifo_trigger_level, .o_enhanced_mode_select,
      .o_flow_resume_char_1, .o_flow_resume_char_2(),
      .o_flow_pause_char_1(), .o_flow_pause_char_2(), .o_pin_irq_enable,
      .o_pin_three_state(), .o_pin_polarity(), .o_pin_function_select);

   uart_engine_model uart_engine_model_inst (
      .i_clock, .i_rst, .i_rx_pop(o_rx_pop),
      .o_receive_holding(i_receive_holding),
      .o_interrupt_status(i_interrupt_status),
      .o_line_status(i_line_status), .o_modem_status(i_modem_status),
      .o_fifo_level_count(i_fifo_level_count));

   // ----------------------------------------------------------------
   // Shared access and compare tasks
   // ----------------------------------------------------------------
   // Byte compare; every comparison of the run goes through here.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One access with an idle cycle after it, so strobes never re-rise
   // in the time step where they fall; strobes are sampled mid-cycle.
   task automatic acc(input logic r, input logic w, input logic [2:0] a,
                      input logic [7:0] d);
      i_rd = r;
      i_wr = w;
      i_addr = a;
      i_wdata = d;
      #4 sb = {1'b0, o_rx_pop, o_tx_push, o_queue_control_wr,
               o_trigger_wr, o_mode_select_wr, o_status_read, o_modem_read};
      @(posedge i_clock);
      #1 i_rd = 1'b0;
      i_wr = 1'b0;
      @(posedge i_clock);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      acc(1'b1, 1'b0, a, 8'h00);
      chk(o_rdata, exp);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Normal bank after reset: every location and its strobes.
   task automatic t_normal;
      chk(o_scratch_pad, 8'h00);
      rd(3'h3, 8'h03);
      wr(3'h0, 8'hAA); chk(sb, 8'h20);
      rd(3'h0, 8'h30); chk(sb, 8'h40);
      rd(3'h0, 8'h31);
      wr(3'h1, 8'h5C); rd(3'h1, 8'h5C);
      rd(3'h2, 8'hC1);
      wr(3'h2, 8'h07); chk(sb, 8'h10); chk(o_queue_control, 8'h07);
      wr(3'h4, 8'h12); rd(3'h4, 8'h12);
      rd(3'h5, 8'h61); chk(sb, 8'h02);
      wr(3'h5, 8'h44); chk(o_rs485_setup_hysteresis, 8'h44);
      rd(3'h6, 8'hA5); chk(sb, 8'h01);
      wr(3'h6, 8'h99); chk(o_special_function, 8'h00);
      wr(3'h7, 8'h3C); rd(3'h7, 8'h3C);
   endtask

   // Divisor bank: revision only while both divisor bytes are zero.
   task automatic t_divisor;
      wr(3'h3, 8'h83); rd(3'h0, `REV_CODE);
      wr(3'h0, 8'h01); rd(3'h0, 8'h01);
      wr(3'h1, 8'h02); rd(3'h1, 8'h02);
      rd(3'h2, 8'hC1);
      wr(3'h3, 8'h03); rd(3'h1, 8'h5C);
   endtask

   // Enhanced bank, both upper pages; the pages must not alias.
   task automatic t_enhanced;
      wr(3'h3, 8'hBF); rd(3'h0, 8'h20);
      wr(3'h0, 8'h0F); chk(sb, 8'h08); chk(o_fifo_trigger_level, 8'h0F);
      wr(3'h1, 8'h40); rd(3'h1, 8'h40);
      wr(3'h2, 8'h10); rd(3'h2, 8'h10);
      for (int i = 4; i < 8; i++) begin
         wr(3'(i), 8'(8'h10 + i)); rd(3'(i), 8'(8'h10 + i));
      end
      wr(3'h3, 8'h03); wr(3'h6, 8'h01); chk(o_special_function, 8'h01);
      wr(3'h3, 8'hBF);
      for (int i = 4; i < 8; i++) begin
         wr(3'(i), 8'(8'h20 + i)); rd(3'(i), 8'(8'h20 + i));
      end
      chk(o_flow_resume_char_1, 8'h14);
      chk(o_pin_irq_enable, 8'h24);
      chk(o_pin_function_select, 8'h27);
      wr(3'h3, 8'h03); rd(3'h7, 8'h00);
      rd(3'h2, 8'hC1);
      wr(3'h6, 8'h00); chk(o_special_function, 8'h00);
   endtask

   // Feature page at 111 and the fractional divisor.
   task automatic t_pages;
      wr(3'h7, 8'h5E); chk(sb, 8'h04); chk(o_enhanced_mode_select, 8'h5E);
      chk(o_scratch_pad, 8'h3C); rd(3'h7, 8'h20);
      wr(3'h3, 8'h83); wr(3'h2, 8'h66); chk(o_divisor_fraction, 8'h66);
      rd(3'h2, 8'h66);
      wr(3'h3, 8'h03);
   endtask

   // ----------------------------------------------------------------
   // Clock, sequence, watchdog and verdict
   // ----------------------------------------------------------------
   task automatic test_done;
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   initial begin
      i_rst = 1'b1;
      i_rd = 1'b0;
      i_wr = 1'b0;
      i_addr = 3'h0;
      i_wdata = 8'h00;
      sb = 8'h00;
      repeat (12) @(posedge i_clock);
      #1 i_rst = 1'b0;
      t_normal;
      t_divisor;
      t_enhanced;
      t_pages;
      test_done;
   end

   // The run needs about 134 cycles; the 2000-cycle limit, about fifteen times that, means a hang.
   initial begin
      #20000;
      n_mismatch++;
      test_done;
   end
endmodule
